// ### status_flags_pkg.sv
// ==========================================================
// register map and field layout of the status flag bank
package status_flags_pkg;

	localparam logic [7:0] SYSTEM_STATUS_FLAGS_OFFSET = 8'h06;
	localparam logic [7:0] SYSTEM_STATUS_FLAGS_RESET  = 8'h00;

	localparam int OVERTEMP_SHUTDOWN_BIT  = 7;
	localparam int OVERCURRENT_CH3_BIT    = 6;
	localparam int OVERCURRENT_CH2_BIT    = 5;
	localparam int OVERCURRENT_CH1_BIT    = 4;
	localparam int THERMAL_WARNING_BIT    = 3;
	localparam int OUTPUT_OK_CH3_BIT      = 2;
	localparam int OUTPUT_OK_CH2_BIT      = 1;
	localparam int OUTPUT_OK_CH1_BIT      = 0;

	// die temperature thresholds, degrees Celsius, for reference by the analog side
	localparam int OVERTEMP_SHUTDOWN_DEGC = 160;
	localparam int THERMAL_WARNING_DEGC   = 125;

	localparam logic [7:0] READ_UNMAPPED_VALUE = 8'h00;

endpackage : status_flags_pkg

// ### converter_fault_status_flags.sv
`timescale 1ns/1ns
module converter_fault_status_flags (
	input  wire logic       i_mclk,
	input  wire logic       i_srst,
	input  wire logic       i_overtemp_shutdown,
	input  wire logic       i_overcurrent_flag_ch3,
	input  wire logic       i_overcurrent_flag_ch2,
	input  wire logic       i_overcurrent_flag_ch1,
	input  wire logic       i_thermal_warning_flag,
	input  wire logic       i_output_ok_ch3,
	input  wire logic       i_output_ok_ch2,
	input  wire logic       i_output_ok_ch1,
	input  wire logic [7:0] i_reg_addr,
	input  wire logic       i_reg_rd,
	input  wire logic       i_reg_wr,
	input  wire logic [7:0] i_reg_wdata,
	output logic      [7:0] o_reg_rdata,
	output logic            o_reg_hit,
	output logic      [7:0] o_status_flags
);

	// ==========================================================
	// field decode helpers

	// true when an offset selects the status register
	function automatic logic is_status_offset(
		input logic [7:0] offset
	);
		is_status_offset = (offset == status_flags_pkg::SYSTEM_STATUS_FLAGS_OFFSET);
	endfunction : is_status_offset

	// places one flag level at its field position, all other bits zero
	function automatic logic [7:0] place_flag(
		input logic level,
		input int   position
	);
		logic [7:0] word;
		word           = status_flags_pkg::SYSTEM_STATUS_FLAGS_RESET;
		word[position] = level;
		place_flag     = word;
	endfunction : place_flag

	// merges three placed fields; fields never share a bit
	function automatic logic [7:0] merge_fields(
		input logic [7:0] first,
		input logic [7:0] second,
		input logic [7:0] third
	);
		merge_fields = first | second | third;
	endfunction : merge_fields

	// ==========================================================
	// signal declarations

	wire  logic [7:0] overtemp_field;
	wire  logic [7:0] overcurrent3_field;
	wire  logic [7:0] overcurrent2_field;
	wire  logic [7:0] overcurrent1_field;
	wire  logic [7:0] warning_field;
	wire  logic [7:0] output_ok3_field;
	wire  logic [7:0] output_ok2_field;
	wire  logic [7:0] output_ok1_field;

	wire  logic [7:0] thermal_group;
	wire  logic [7:0] overcurrent_group;
	wire  logic [7:0] output_ok_group;
	wire  logic [7:0] status_next;
	logic       [7:0] status_reg;

	wire  logic       addr_match;
	wire  logic       read_status;
	wire  logic       read_unmapped;
	wire  logic       read_any;
	wire  logic [7:0] read_word;
	wire  logic [7:0] rdata_next;
	wire  logic       hit_next;
	logic       [7:0] rdata_reg;
	logic             hit_reg;

	wire  logic       write_to_status;
	wire  logic       write_elsewhere;
	wire  logic       write_unused;

	// ==========================================================
	// overtemperature shutdown field

	assign overtemp_field = place_flag(
		i_overtemp_shutdown,
		status_flags_pkg::OVERTEMP_SHUTDOWN_BIT
	);

	// ==========================================================
	// overcurrent fields, one per converter

	assign overcurrent3_field = place_flag(
		i_overcurrent_flag_ch3,
		status_flags_pkg::OVERCURRENT_CH3_BIT
	);

	assign overcurrent2_field = place_flag(
		i_overcurrent_flag_ch2,
		status_flags_pkg::OVERCURRENT_CH2_BIT
	);

	assign overcurrent1_field = place_flag(
		i_overcurrent_flag_ch1,
		status_flags_pkg::OVERCURRENT_CH1_BIT
	);

	// ==========================================================
	// thermal warning field

	assign warning_field = place_flag(
		i_thermal_warning_flag,
		status_flags_pkg::THERMAL_WARNING_BIT
	);

	// ==========================================================
	// output ok fields, one per output

	assign output_ok3_field = place_flag(
		i_output_ok_ch3,
		status_flags_pkg::OUTPUT_OK_CH3_BIT
	);

	assign output_ok2_field = place_flag(
		i_output_ok_ch2,
		status_flags_pkg::OUTPUT_OK_CH2_BIT
	);

	assign output_ok1_field = place_flag(
		i_output_ok_ch1,
		status_flags_pkg::OUTPUT_OK_CH1_BIT
	);

	// ==========================================================
	// field merge

	assign thermal_group = merge_fields(
		overtemp_field,
		warning_field,
		status_flags_pkg::SYSTEM_STATUS_FLAGS_RESET
	);

	assign overcurrent_group = merge_fields(
		overcurrent3_field,
		overcurrent2_field,
		overcurrent1_field
	);

	assign output_ok_group = merge_fields(
		output_ok3_field,
		output_ok2_field,
		output_ok1_field
	);

	assign status_next = merge_fields(
		thermal_group,
		overcurrent_group,
		output_ok_group
	);

	// ==========================================================
	// live status register

	// sampled every clock, not sticky: a cleared source clears its bit
	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			status_reg <= status_flags_pkg::SYSTEM_STATUS_FLAGS_RESET;
		end else begin
			status_reg <= status_next;
		end
	end

	// ==========================================================
	// register read port

	assign addr_match    = is_status_offset(i_reg_addr);
	assign read_status   = i_reg_rd & addr_match;
	assign read_unmapped = i_reg_rd & ~addr_match;
	assign read_any      = read_status | read_unmapped;

	assign read_word = read_status
		? status_reg
		: status_flags_pkg::READ_UNMAPPED_VALUE;

	// read data stands until the next read, whatever the address
	assign rdata_next = read_any
		? read_word
		: rdata_reg;
	assign hit_next   = read_status;

	// ==========================================================
	// read data and hit flops

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			rdata_reg <= status_flags_pkg::SYSTEM_STATUS_FLAGS_RESET;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_srst) begin
			hit_reg <= 1'b0;
		end else begin
			hit_reg <= hit_next;
		end
	end

	// ==========================================================
	// write path, accepted and dropped

	// a write never reaches any register
	assign write_to_status = i_reg_wr & is_status_offset(i_reg_addr);
	assign write_elsewhere = i_reg_wr & ~is_status_offset(i_reg_addr);
	assign write_unused    = (write_to_status | write_elsewhere) & (|i_reg_wdata);

	// ==========================================================
	// outputs

	assign o_status_flags = status_reg;
	assign o_reg_rdata    = rdata_reg;
	assign o_reg_hit      = hit_reg;

endmodule : converter_fault_status_flags

// ### flags_props.sv
`timescale 1ns/1ns
module flags_props(input wire logic i_mclk,i_srst,i_reg_rd,o_reg_hit,i_overtemp_shutdown,i_thermal_warning_flag,
	input wire logic i_overcurrent_flag_ch3,i_overcurrent_flag_ch2,i_overcurrent_flag_ch1,i_output_ok_ch3,
	input wire logic i_output_ok_ch2,i_output_ok_ch1,input wire logic [7:0] i_reg_addr,o_reg_rdata,o_status_flags);
default clocking @(posedge i_mclk); endclocking
default disable iff (i_srst);
property p_hit; i_reg_rd && i_reg_addr==8'h06 |=> o_reg_hit; endproperty
a_hit: assert property(p_hit) else $error("read missed");
property p_miss; i_reg_rd && i_reg_addr!=8'h06 |=> !o_reg_hit && o_reg_rdata==8'h00; endproperty
a_miss: assert property(p_miss) else $error("stray hit");
property p_rd; o_reg_hit |-> o_reg_rdata==$past(o_status_flags); endproperty
a_rd: assert property(p_rd) else $error("bad read data");
property p_src; !$past(i_srst) |-> o_status_flags==$past({i_overtemp_shutdown,i_overcurrent_flag_ch3,
	i_overcurrent_flag_ch2,i_overcurrent_flag_ch1,i_thermal_warning_flag,i_output_ok_ch3,i_output_ok_ch2,
	i_output_ok_ch1}); endproperty
a_src: assert property(p_src) else $error("flag mismatch");
property p_rst; $past(i_srst) |-> o_status_flags==8'h00 && !o_reg_hit; endproperty
a_rst: assert property(p_rst) else $error("not cleared");
property p_hold; !i_reg_rd |=> !o_reg_hit && $stable(o_reg_rdata); endproperty
a_hold: assert property(p_hold) else $error("read port moved without a read");
c_hit: cover property(o_reg_hit);
c_set: cover property(o_reg_hit && o_reg_rdata!=8'h00);
c_rst: cover property($past(i_srst));
endmodule:flags_props

// ### host_reader.sv
`timescale 1ns/1ns
module host_reader(input wire logic i_mclk,output logic [7:0] o_reg_addr,o_reg_wdata,output logic o_reg_rd,o_reg_wr);
initial {o_reg_addr,o_reg_wdata,o_reg_rd,o_reg_wr}=18'h0_0000;
task acc(input logic w,input logic [7:0] ad,d);
	@(posedge i_mclk) {o_reg_addr,o_reg_wdata,o_reg_rd,o_reg_wr}<={ad,d,!w,w};
	@(posedge i_mclk) {o_reg_wdata,o_reg_rd,o_reg_wr}<={~d,2'h0};
endtask:acc
endmodule:host_reader

// ### testbench.sv
`timescale 1ns/1ns
module testbench;
logic i_mclk=0,i_srst=1,rd,wr,hit;
logic [7:0] s=8'h00,a,wd,rdata,flags;
int fail_count=0,n_checks=0,cyc=0;
initial forever #10 i_mclk=~i_mclk;
host_reader h(.i_mclk(i_mclk),.o_reg_addr(a),.o_reg_wdata(wd),.o_reg_rd(rd),.o_reg_wr(wr));
converter_fault_status_flags dut(.i_mclk(i_mclk),.i_srst(i_srst),.i_overtemp_shutdown(s[7]),
	.i_overcurrent_flag_ch3(s[6]),.i_overcurrent_flag_ch2(s[5]),.i_overcurrent_flag_ch1(s[4]),
	.i_thermal_warning_flag(s[3]),.i_output_ok_ch3(s[2]),.i_output_ok_ch2(s[1]),.i_output_ok_ch1(s[0]),
	.i_reg_addr(a),.i_reg_rd(rd),.i_reg_wr(wr),.i_reg_wdata(wd),.o_reg_rdata(rdata),.o_reg_hit(hit),.o_status_flags(flags));
task chk(input string nm,input logic [7:0] got,exp);
	n_checks++;
	if (got!==exp) begin $display("BAD %s exp %h got %h",nm,exp,got); fail_count++; end
endtask:chk
task rchk(input logic [7:0] ad,exp);
	h.acc(1'b0,ad,8'h00);
	#1 chk("rdata",rdata,exp);
	chk("hit",{7'h00,hit},{7'h00,ad==8'h06});
endtask:rchk
task close_out;
	$display("checks %0d bad %0d",n_checks,fail_count);
	if (fail_count==0 && n_checks>0) $display("DONE - PASS"); else $display("DONE - FAIL");
	$finish;
endtask:close_out
always @(posedge i_mclk) begin cyc<=cyc+1; if (cyc==600) begin fail_count++; close_out; end end
initial begin
	repeat (4) @(posedge i_mclk);
	i_srst<=1'b0;
	rchk(8'h06,8'h00);
	$display("test reset value done");
	for (int i=0;i<8;i++) begin @(posedge i_mclk) s<=8'h01<<i; rchk(8'h06,8'h01<<i); end
	$display("test field walk done");
	h.acc(1'b1,8'h06,8'h00);
	#1 chk("hit",{7'h00,hit},8'h00);
	chk("flags",flags,8'h80);
	rchk(8'h06,8'h80);
	$display("test write ignored done");
	rchk(8'h07,8'h00);
	$display("test unmapped read done");
	@(posedge i_mclk) i_srst<=1'b1;
	@(posedge i_mclk) i_srst<=1'b0;
	#1 chk("flags",flags,8'h00);
	@(posedge i_mclk) #1 chk("flags",flags,8'h80);
	$display("test mid-run reset done");
	close_out;
end
endmodule:testbench
bind converter_fault_status_flags flags_props u_props(.*);
